// [rtl/pmpm_pkg.sv]
package pmpm_pkg;
    localparam logic [1:0] MODE_MASTER2 = 2'h2;
    localparam logic [1:0] MODE_MASTER1 = 2'h3;
    localparam logic [1:0] MUX_DEMUX = 2'h0;
    localparam logic [1:0] MUX_PART = 2'h1;
    localparam logic [1:0] MUX_FULL = 2'h2;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int WAIT_W = 4;
    localparam int CNT_W = 5;
    // Extra read cycles cover the two-stage input synchroniser
    localparam logic [CNT_W-1:0] READ_EXTRA = 5'h02;
    localparam int ALL_PIN = 0;
    localparam int ALH_PIN = 1;
    localparam int CS1_PIN = 14;
    localparam int CS2_PIN = 15;
    localparam int PART_LOW_PINS = 8;

    typedef enum logic [4:0] {
        PMPM_IDLE = 5'h01,
        PMPM_ALO = 5'h02,
        PMPM_AHI = 5'h04,
        PMPM_XFER = 5'h08,
        PMPM_GAP = 5'h10
    } pmpm_state_t;

    typedef struct packed {
        logic rd;
        logic wr_en;
        logic be;
        logic al;
        logic cs1;
        logic cs2;
    } pmpm_pol_t;

    typedef struct packed {
        logic be;
        logic wr;
        logic rd;
    } pmpm_pin_on_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic data_oe_n;
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] addr_on;
        logic rd;
        logic wr;
        logic be;
        logic rd_on;
        logic wr_on;
        logic be_on;
    } pmpm_pins_t;

    localparam pmpm_pins_t PINS_IDLE = '{data_oe_n: 1'b1, default: '0};

    typedef struct packed {
        pmpm_state_t st;
        logic [1:0] mux;
        logic write;
        logic wide;
        logic hi_byte;
        logic [CNT_W-1:0] wcnt;
        logic [ADDR_W-1:0] addr;
        logic [2*DATA_W-1:0] wdata;
        logic [2*DATA_W-1:0] rdata;
        logic done;
        pmpm_pins_t pins;
    } pmpm_regs_t;
endpackage

// [rtl/pmpm_sync.sv]
`timescale 1ns/1ns
module pmpm_sync #(
    parameter int W = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// [rtl/pmpm_master.sv]
`timescale 1ns/1ns
module pmpm_master (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic port_master_enable,
    input wire logic [1:0] master_mode_select,
    input wire logic wide_data_select,
    input wire logic [1:0] address_mux_select,
    input wire pmpm_pkg::pmpm_pol_t polarity,
    input wire pmpm_pkg::pmpm_pin_on_t strobe_pins_on,
    input wire logic [pmpm_pkg::ADDR_W-1:0] address_pin_enables,
    input wire logic [1:0] cs_pin_select,
    input wire logic [pmpm_pkg::WAIT_W-1:0] data_wait,
    input wire logic [pmpm_pkg::ADDR_W-1:0] address_register,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [2*pmpm_pkg::DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic xfer_done,
    output logic [2*pmpm_pkg::DATA_W-1:0] rd_data,
    input wire logic [pmpm_pkg::DATA_W-1:0] bus_data_pins_in,
    output pmpm_pkg::pmpm_pins_t pins
);
    pmpm_pkg::pmpm_regs_t s;
    pmpm_pkg::pmpm_regs_t next_s;
    logic [pmpm_pkg::DATA_W-1:0] data_sync;
    logic master_on;
    logic go;

    function automatic logic lvl(input logic act, input logic pol);
        return pol ? act : ~act;
    endfunction

    pmpm_sync #(.W(pmpm_pkg::DATA_W)) u_data_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .d(bus_data_pins_in),
        .q(data_sync)
    );

    assign master_on = port_master_enable & master_mode_select[1];
    assign req_ready = master_on & (s.st == pmpm_pkg::PMPM_IDLE);
    assign go = req_valid & req_ready;
    assign xfer_done = s.done;
    assign rd_data = s.rdata;
    assign pins = s.pins;

    always_comb begin
        pmpm_pkg::pmpm_pins_t p;
        logic xfer;
        logic busy;
        logic v;
        logic [pmpm_pkg::CNT_W-1:0] wl;
        logic [pmpm_pkg::DATA_W-1:0] hi_masked;
        p = pmpm_pkg::PINS_IDLE;
        xfer = 1'b0;
        busy = 1'b0;
        v = 1'b0;
        hi_masked = '0;
        next_s = s;
        next_s.done = 1'b0;
        // Reads stay longer so the synchronised bus is valid at capture
        wl = {1'b0, data_wait};
        if (!((s.st == pmpm_pkg::PMPM_IDLE) ? req_write : s.write)) begin
            wl = wl + pmpm_pkg::READ_EXTRA;
        end
        case (s.st)
            pmpm_pkg::PMPM_IDLE: begin
                next_s.mux = address_mux_select;
                if (go) begin
                    next_s.write = req_write;
                    next_s.wide = wide_data_select;
                    next_s.hi_byte = 1'b0;
                    next_s.addr = address_register;
                    next_s.wdata = req_wdata;
                    next_s.wcnt = wl;
                    if (address_mux_select == pmpm_pkg::MUX_PART ||
                        address_mux_select == pmpm_pkg::MUX_FULL) begin
                        next_s.st = pmpm_pkg::PMPM_ALO;
                    end else begin
                        next_s.st = pmpm_pkg::PMPM_XFER;
                    end
                end
            end
            pmpm_pkg::PMPM_ALO: begin
                if (s.mux == pmpm_pkg::MUX_FULL) begin
                    next_s.st = pmpm_pkg::PMPM_AHI;
                end else begin
                    next_s.st = pmpm_pkg::PMPM_XFER;
                end
            end
            pmpm_pkg::PMPM_AHI: begin
                next_s.st = pmpm_pkg::PMPM_XFER;
            end
            pmpm_pkg::PMPM_XFER: begin
                if (s.wcnt != '0) begin
                    next_s.wcnt = s.wcnt - 5'h01;
                end else begin
                    if (!s.write) begin
                        if (s.hi_byte) begin
                            next_s.rdata[15:8] = data_sync;
                        end else begin
                            next_s.rdata[7:0] = data_sync;
                        end
                    end
                    if (s.wide && !s.hi_byte) begin
                        next_s.hi_byte = 1'b1;
                        next_s.st = pmpm_pkg::PMPM_GAP;
                    end else begin
                        next_s.st = pmpm_pkg::PMPM_IDLE;
                        next_s.done = 1'b1;
                    end
                end
            end
            pmpm_pkg::PMPM_GAP: begin
                // One strobe-free cycle gives each byte its own edge
                next_s.wcnt = wl;
                next_s.st = pmpm_pkg::PMPM_XFER;
            end
            default: begin
                next_s.st = pmpm_pkg::PMPM_IDLE;
            end
        endcase

        xfer = next_s.st == pmpm_pkg::PMPM_XFER;
        busy = next_s.st != pmpm_pkg::PMPM_IDLE;
        hi_masked = next_s.addr[15:8] & ~{cs_pin_select, 6'h00};
        if (master_on) begin
            case (next_s.st)
                pmpm_pkg::PMPM_ALO: p.data = next_s.addr[7:0];
                pmpm_pkg::PMPM_AHI: p.data = hi_masked;
                default: p.data = next_s.hi_byte ? next_s.wdata[15:8] : next_s.wdata[7:0];
            endcase
            p.data_oe_n = ~((next_s.st == pmpm_pkg::PMPM_ALO) |
                            (next_s.st == pmpm_pkg::PMPM_AHI) |
                            (xfer & next_s.write));
            if (master_mode_select == pmpm_pkg::MODE_MASTER1) begin
                p.rd = lvl(busy & ~next_s.write, polarity.rd);
                p.wr = lvl(xfer, polarity.wr_en);
            end else begin
                p.rd = lvl(xfer & ~next_s.write, polarity.rd);
                p.wr = lvl(xfer & next_s.write, polarity.wr_en);
            end
            p.be = lvl(xfer & next_s.hi_byte, polarity.be);
            p.rd_on = strobe_pins_on.rd;
            p.wr_on = strobe_pins_on.wr;
            p.be_on = strobe_pins_on.be;
            p.rd = p.rd & p.rd_on;
            p.wr = p.wr & p.wr_on;
            p.be = p.be & p.be_on;
            for (int i = 0; i < pmpm_pkg::ADDR_W; i++) begin
                v = next_s.addr[i];
                if (i == pmpm_pkg::CS1_PIN && cs_pin_select[0]) begin
                    v = lvl(busy & next_s.addr[i], polarity.cs1);
                end else if (i == pmpm_pkg::CS2_PIN && cs_pin_select[1]) begin
                    v = lvl(busy & next_s.addr[i], polarity.cs2);
                // Mux 11 behaves as demultiplexed, so pin 0 keeps its address bit
                end else if (i == pmpm_pkg::ALL_PIN && (next_s.mux == pmpm_pkg::MUX_PART ||
                             next_s.mux == pmpm_pkg::MUX_FULL)) begin
                    v = lvl(next_s.st == pmpm_pkg::PMPM_ALO, polarity.al);
                end else if (i == pmpm_pkg::ALH_PIN && next_s.mux == pmpm_pkg::MUX_FULL) begin
                    v = lvl(next_s.st == pmpm_pkg::PMPM_AHI, polarity.al);
                end else if (next_s.mux == pmpm_pkg::MUX_FULL ||
                             (next_s.mux == pmpm_pkg::MUX_PART && i < pmpm_pkg::PART_LOW_PINS)) begin
                    v = 1'b0;
                end
                p.addr_on[i] = address_pin_enables[i];
                p.addr[i] = v & address_pin_enables[i];
            end
        end
        next_s.pins = p;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= '{st: pmpm_pkg::PMPM_IDLE, pins: pmpm_pkg::PINS_IDLE, default: '0};
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_idle_without_master: assert property (
        (s.st == pmpm_pkg::PMPM_IDLE && !master_on) |=> s.st == pmpm_pkg::PMPM_IDLE)
        else $error("transfer started outside master mode");
    a_pin_off_gpio: assert property (
        !$past(address_pin_enables[5]) |-> (!s.pins.addr_on[5] && !s.pins.addr[5]))
        else $error("disabled address pin still claimed");
    a_strobe_pin_off: assert property (
        !$past(strobe_pins_on.rd) |-> (!s.pins.rd_on && !s.pins.rd))
        else $error("disabled read strobe pin still claimed");
    a_addr_pin_drive: assert property (
        ($past(master_on && address_pin_enables[3]) && s.mux == pmpm_pkg::MUX_DEMUX)
        |-> s.pins.addr[3] == s.addr[3])
        else $error("address pin differs from address bit");
    a_low_latch_pin: assert property (
        (s.st == pmpm_pkg::PMPM_ALO && $past(master_on && address_pin_enables[0]))
        |-> s.pins.addr[0] == $past(polarity.al))
        else $error("low latch strobe not active on pin 0");
    a_high_latch_pin: assert property (
        (s.st == pmpm_pkg::PMPM_AHI && $past(master_on && address_pin_enables[1]))
        |-> s.pins.addr[1] == $past(polarity.al))
        else $error("high latch strobe not active on pin 1");
    a_mode1_enable: assert property (
        (s.st == pmpm_pkg::PMPM_XFER &&
         $past(master_on && master_mode_select == pmpm_pkg::MODE_MASTER1 && strobe_pins_on.wr))
        |-> s.pins.wr == $past(polarity.wr_en))
        else $error("enable strobe inactive during transfer");
    a_mode1_direction: assert property (
        (s.st != pmpm_pkg::PMPM_IDLE && !s.write &&
         $past(master_on && master_mode_select == pmpm_pkg::MODE_MASTER1 && strobe_pins_on.rd))
        |-> s.pins.rd == $past(polarity.rd))
        else $error("direction line not at read for whole read");
    a_mode2_read: assert property (
        (s.st == pmpm_pkg::PMPM_XFER && !s.write &&
         $past(master_on && master_mode_select == pmpm_pkg::MODE_MASTER2 && strobe_pins_on.rd))
        |-> s.pins.rd == $past(polarity.rd))
        else $error("read strobe inactive during read");
    a_mode2_no_write: assert property (
        (s.st == pmpm_pkg::PMPM_XFER && !s.write &&
         $past(master_on && master_mode_select == pmpm_pkg::MODE_MASTER2 && strobe_pins_on.wr))
        |-> s.pins.wr == ~$past(polarity.wr_en))
        else $error("write strobe active during read");
    a_chip_select_level: assert property (
        (s.st != pmpm_pkg::PMPM_IDLE &&
         $past(master_on && address_pin_enables[pmpm_pkg::CS2_PIN] && cs_pin_select[1]))
        |-> s.pins.addr[pmpm_pkg::CS2_PIN] == ~(s.addr[pmpm_pkg::CS2_PIN] ^ $past(polarity.cs2)))
        else $error("chip select 2 level wrong during transfer");
    a_write_data_out: assert property (
        (s.st == pmpm_pkg::PMPM_XFER && s.write && $past(master_on))
        |-> (!s.pins.data_oe_n &&
             s.pins.data == (s.hi_byte ? s.wdata[15:8] : s.wdata[7:0])))
        else $error("write byte not driven");
    a_read_bus_free: assert property (
        (s.st == pmpm_pkg::PMPM_XFER && !s.write) |-> s.pins.data_oe_n)
        else $error("data pins driven during read strobe");
    a_narrow_end: assert property (
        (s.st == pmpm_pkg::PMPM_XFER && s.wcnt == '0 && !s.wide)
        |=> (s.done && s.st == pmpm_pkg::PMPM_IDLE))
        else $error("8-bit transfer did not end");
    a_done_pulse: assert property (
        s.done |=> !s.done)
        else $error("done held longer than one cycle");
    a_wide_split: assert property (
        (s.st == pmpm_pkg::PMPM_XFER && s.wcnt == '0 && s.wide && !s.hi_byte)
        |=> s.st == pmpm_pkg::PMPM_GAP ##1 (s.st == pmpm_pkg::PMPM_XFER && s.hi_byte))
        else $error("16-bit transfer not split low then high");
    a_byte_enable_hi: assert property (
        (s.st == pmpm_pkg::PMPM_XFER && s.hi_byte && $past(master_on && strobe_pins_on.be))
        |-> s.pins.be == $past(polarity.be))
        else $error("byte enable missing on high byte");
    a_low_byte_be: assert property (
        (s.st == pmpm_pkg::PMPM_XFER && !s.hi_byte && $past(master_on && strobe_pins_on.be))
        |-> s.pins.be == ~$past(polarity.be))
        else $error("byte enable active on low byte");
    a_gap_strobes_off: assert property (
        (s.st == pmpm_pkg::PMPM_GAP &&
         $past(master_on && strobe_pins_on.wr && strobe_pins_on.be))
        |-> (s.pins.wr == ~$past(polarity.wr_en) && s.pins.be == ~$past(polarity.be)))
        else $error("strobe active in the gap between bytes");
    a_read_low_capture: assert property (
        (s.st == pmpm_pkg::PMPM_XFER && s.wcnt == '0 && !s.write && !s.hi_byte)
        |=> s.rdata[7:0] == $past(data_sync))
        else $error("low read byte not captured");
    a_read_high_capture: assert property (
        (s.st == pmpm_pkg::PMPM_XFER && s.wcnt == '0 && !s.write && s.hi_byte)
        |=> s.rdata[15:8] == $past(data_sync))
        else $error("high read byte not captured");
    a_demux_direct: assert property (
        (s.st != pmpm_pkg::PMPM_IDLE && s.mux == pmpm_pkg::MUX_DEMUX)
        |-> s.st inside {pmpm_pkg::PMPM_XFER, pmpm_pkg::PMPM_GAP})
        else $error("address phase in demultiplexed mode");
    a_part_one_cycle: assert property (
        (s.st == pmpm_pkg::PMPM_ALO && s.mux == pmpm_pkg::MUX_PART)
        |=> s.st == pmpm_pkg::PMPM_XFER)
        else $error("partial mux address phase not one cycle");
    a_part_upper_pins: assert property (
        (s.mux == pmpm_pkg::MUX_PART && $past(master_on && address_pin_enables[9]))
        |-> s.pins.addr[9] == s.addr[9])
        else $error("upper address pin not driven in partial mux");
    a_full_two_cycles: assert property (
        (s.st == pmpm_pkg::PMPM_ALO && s.mux == pmpm_pkg::MUX_FULL)
        |=> s.st == pmpm_pkg::PMPM_AHI ##1 s.st == pmpm_pkg::PMPM_XFER)
        else $error("full mux address phases wrong");
    a_full_pins_zero: assert property (
        s.mux == pmpm_pkg::MUX_FULL |-> !s.pins.addr[5])
        else $error("address pin not cleared in full mux");
    a_cs_forced_zero: assert property (
        (s.st == pmpm_pkg::PMPM_AHI && $past(master_on && cs_pin_select[1]))
        |-> !s.pins.data[7])
        else $error("chip select bit not zero in high address");
    a_wait_hold: assert property (
        (s.st == pmpm_pkg::PMPM_XFER && s.wcnt != '0)
        |=> (s.st == pmpm_pkg::PMPM_XFER && s.wcnt == $past(s.wcnt) - 5'h01))
        else $error("strobe released before wait cycles ended");

    c_full_write: cover property (
        s.st == pmpm_pkg::PMPM_AHI ##1 (s.st == pmpm_pkg::PMPM_XFER && s.write));
    c_wide_read: cover property (
        s.st == pmpm_pkg::PMPM_GAP ##[1:40] (s.done && !s.write));
    c_part_mux: cover property (
        s.st == pmpm_pkg::PMPM_ALO && s.mux == pmpm_pkg::MUX_PART);
    c_mode1_read: cover property (
        s.done && !s.write && master_mode_select == pmpm_pkg::MODE_MASTER1);
endmodule

// [testbench/pmpm_ext_dev.sv]
`timescale 1ns/1ns
module pmpm_ext_dev (
    input wire logic clk_sys,
    input wire logic [1:0] master_mode_select,
    input wire pmpm_pkg::pmpm_pol_t polarity,
    input wire pmpm_pkg::pmpm_pins_t pins,
    output logic [7:0] bus_data_pins_in,
    output logic [15:0] lat_addr,
    output logic [15:0] wr_seen
);
    logic [7:0] last;
    logic dir_rd;
    logic strobe;
    logic hi;
    logic rd_act;
    logic wr_act;
    initial begin
        last = 8'h00;
        lat_addr = 16'h0000;
        wr_seen = 16'h0000;
    end
    assign dir_rd = pins.rd_on && (pins.rd == polarity.rd);
    assign strobe = pins.wr_on && (pins.wr == polarity.wr_en);
    assign hi = pins.be_on && (pins.be == polarity.be);
    // First mode: direction plus enable strobe; second: own read and write strobes
    assign rd_act = (master_mode_select == 2'h3) ? (dir_rd && strobe) : dir_rd;
    assign wr_act = (master_mode_select == 2'h3) ? (!dir_rd && strobe) : strobe;
    // A released bus shows a changing pattern, never the last value
    assign bus_data_pins_in = rd_act ? (hi ? 8'ha5 : 8'h3c) : ~last;
    always @(posedge clk_sys) begin
        last <= bus_data_pins_in;
        if (pins.addr_on[0] && pins.addr[0] == polarity.al && !pins.data_oe_n) begin
            lat_addr[7:0] <= pins.data;
        end
        if (pins.addr_on[1] && pins.addr[1] == polarity.al && !pins.data_oe_n) begin
            lat_addr[15:8] <= pins.data;
        end
        if (wr_act && !pins.data_oe_n) begin
            if (hi) begin
                wr_seen[15:8] <= pins.data;
            end else begin
                wr_seen[7:0] <= pins.data;
            end
        end
    end
endmodule

// [testbench/parallel_master_port_master_modes_tb_top.sv]
`timescale 1ns/1ns
module parallel_master_port_master_modes_tb_top;
    logic clk_sys, rst, en, wide, req_valid, req_write, req_ready, xfer_done;
    logic [1:0] mode, mux, cs_sel;
    logic [3:0] dwait;
    logic [15:0] ape, areg, wdata, rd_data, lat_addr, wr_seen;
    logic [7:0] din;
    pmpm_pkg::pmpm_pol_t pol;
    pmpm_pkg::pmpm_pin_on_t pon;
    pmpm_pkg::pmpm_pins_t pins;
    int fails, samples_checked;

    pmpm_master dut_u (.clk_sys(clk_sys), .rst(rst), .port_master_enable(en),
        .master_mode_select(mode), .wide_data_select(wide), .address_mux_select(mux),
        .polarity(pol), .strobe_pins_on(pon), .address_pin_enables(ape),
        .cs_pin_select(cs_sel), .data_wait(dwait), .address_register(areg),
        .req_valid(req_valid), .req_write(req_write), .req_wdata(wdata),
        .req_ready(req_ready), .xfer_done(xfer_done), .rd_data(rd_data),
        .bus_data_pins_in(din), .pins(pins));
    pmpm_ext_dev ext_u (.clk_sys(clk_sys), .master_mode_select(mode), .polarity(pol),
        .pins(pins), .bus_data_pins_in(din), .lat_addr(lat_addr), .wr_seen(wr_seen));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // One whole transfer; latency, address pins, latched address and data judged here
    task automatic go(input logic w, input logic wd, input logic [1:0] mx,
        input logic [15:0] a, input logic [15:0] d);
        int n;
        int t;
        int e;
        logic [15:0] a1;
        logic [15:0] m;
        t = int'(dwait) + (w ? 0 : 2);
        e = (mx == 2'h1 ? 1 : mx == 2'h2 ? 2 : 0) + (wd ? 2 : 1) * (t + 2);
        m = wd ? 16'hffff : 16'h00ff;
        wide = wd;
        mux = mx;
        areg = a;
        wdata = d;
        req_write = w;
        req_valid = 1'b1;
        n = 0;
        while (req_ready !== 1'b1) begin
            cyc(1);
            n++;
            if (n > 50) begin
                chk("ready wait", 16'h0001, 16'h0000);
                print_verdict();
            end
        end
        cyc(1);
        req_valid = 1'b0;
        n = 1;
        a1 = pins.addr;
        while (xfer_done !== 1'b1) begin
            cyc(1);
            n++;
            if (n > 100) begin
                chk("done wait", 16'h0001, 16'h0000);
                print_verdict();
            end
        end
        chk("latency", 16'(n), 16'(e));
        if (mx[0] == mx[1]) chk("address pins", a1, a & ape);
        if (mx == 2'h1) chk("low address pins", a1 & 16'h00fe, 16'h0000);
        if (w) chk("written", wr_seen & m, d & m);
        if (!w) chk("read", rd_data & m, 16'ha53c & m);
        if (mx == 2'h1) chk("low latch", {8'h00, lat_addr[7:0]}, {8'h00, a[7:0]});
        if (mx == 2'h2) chk("full latch", lat_addr, a & ~{cs_sel, 14'h0000});
        if (mx == 2'h2) chk("full pins", a1 & 16'hfffc, a & {cs_sel, 14'h0000});
    endtask

    task automatic s_enable();
        chk("reset oe", 16'(pins.data_oe_n), 16'h0001);
        chk("ready off", 16'(req_ready), 16'h0000);
        en = 1'b1;
        mode = 2'h1;
        cyc(2);
        chk("ready slave", 16'(req_ready), 16'h0000);
        mode = 2'h2;
        cyc(2);
        chk("ready master", 16'(req_ready), 16'h0001);
        chk("read pin on", {pins.rd_on, pins.rd}, 16'h0002);
        pon = '0;
        cyc(2);
        chk("pins off", {pins.rd_on, pins.wr_on, pins.be_on}, 16'h0000);
        pon = '1;
        cyc(2);
    endtask

    task automatic s_demux();
        ape = 16'h0f0f;
        go(1'b1, 1'b0, 2'h0, 16'h1234, 16'h00aa);
        go(1'b1, 1'b1, 2'h0, 16'h2345, 16'h55cc);
        dwait = 4'h2;
        go(1'b0, 1'b1, 2'h3, 16'h3457, 16'h0000);
        dwait = 4'h0;
    endtask

    task automatic s_mux();
        ape = 16'hffff;
        go(1'b0, 1'b1, 2'h1, 16'h4567, 16'h0000);
        cs_sel = 2'h3;
        go(1'b1, 1'b0, 2'h2, 16'hc678, 16'h0099);
        cs_sel = 2'h0;
    endtask

    task automatic s_polarity();
        pol = '0;
        mode = 2'h3;
        cyc(2);
        chk("idle low-active", {pins.rd, pins.wr}, 16'h0003);
        go(1'b1, 1'b0, 2'h2, 16'h1357, 16'h0042);
        go(1'b0, 1'b1, 2'h0, 16'h2468, 16'h0000);
    endtask

    initial begin
        rst = 1'b1;
        en = 1'b0;
        mode = 2'h2;
        wide = 1'b0;
        mux = 2'h0;
        cs_sel = 2'h0;
        dwait = 4'h0;
        ape = 16'hffff;
        areg = 16'h0000;
        wdata = 16'h0000;
        req_valid = 1'b0;
        req_write = 1'b0;
        pol = '1;
        pon = '1;
        fails = 0;
        samples_checked = 0;
        cyc(3);
        rst = 1'b0;
        s_enable();
        s_demux();
        s_mux();
        s_polarity();
        print_verdict();
    end
endmodule
